/* gauge_pkg.sv */
// Shared constants, types and helpers for the charge accumulator control block
package gauge_pkg;

  // ***************************************************************
  // Channel slots and control byte layout
  // ***************************************************************
  localparam int NUM_CH = 8;
  localparam logic [2:0] CH_CURRENT = 3'h0;
  localparam logic [2:0] CH_ITEMP = 3'h1;
  localparam logic [2:0] CH_ETEMP = 3'h2;
  localparam logic [2:0] CH_PACK = 3'h3;
  localparam logic [2:0] CH_RSVD = 3'h4;
  localparam logic [2:0] CH_AUX = 3'h5;
  localparam logic [2:0] CH_ZERO = 3'h6;
  localparam int EN_BIT = 7;
  localparam int RES_MSB = 6;
  localparam int RES_LSB = 4;
  localparam int REF_BIT = 3;
  localparam int SEL_MSB = 2;
  localparam int SEL_LSB = 0;

  // Input select codes
  localparam logic [2:0] SEL_SENSE = 3'h0;
  localparam logic [2:0] SEL_ITEMP = 3'h1;
  localparam logic [2:0] SEL_THERM = 3'h2;
  localparam logic [2:0] SEL_PACK = 3'h3;
  localparam logic [2:0] SEL_AUX = 3'h5;
  localparam logic [2:0] SEL_ZERO = 3'h6;

  // ***************************************************************
  // Result and sum formats, reset values
  // ***************************************************************
  localparam logic [3:0] MIN_BITS = 4'h8;
  localparam logic [3:0] MAX_BITS = 4'hf;
  localparam int SIGN_BIT = 15;
  localparam int MAG_W = 15;
  localparam int RES_W = 16;
  localparam int SUM_W = 32;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] SUM_CTRL_RST = 8'h00;
  localparam logic [15:0] RES_RST = 16'h0000;
  localparam logic [31:0] SUM_RST = 32'h0000_0000;
  localparam logic [31:0] TIME_STEP = 32'h0000_0001;
  localparam int SUM_EN_BIT = 0;
  localparam int TEMP_EN_BIT = 1;
  localparam int AUX_EN_BIT = 2;
  localparam int TEMP_SRC_BIT = 3;

  // ***************************************************************
  // Register indices on the host port
  // ***************************************************************
  localparam int ADDR_W = 5;
  localparam logic [4:0] A_RES_BASE = 5'h08;
  localparam logic [4:0] A_SUM_CTRL = 5'h10;
  localparam logic [4:0] A_DSUM = 5'h11;
  localparam logic [4:0] A_CSUM = 5'h12;
  localparam logic [4:0] A_TSUM = 5'h13;
  localparam logic [4:0] A_ASUM = 5'h14;
  localparam logic [4:0] A_DTIME = 5'h15;
  localparam logic [4:0] A_CTIME = 5'h16;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CONV_UNIT_PS = 30520;
  localparam int CONV_UNIT_CYC = (CONV_UNIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_PERIOD_MS = 500;
  localparam int TICK_CYC = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {S_PICK, S_CONV} seq_e;

  function automatic logic [3:0] res_bits(input logic [7:0] ctrl);
    return MIN_BITS + {1'b0, ctrl[RES_MSB:RES_LSB]};
  endfunction

  // Ones over the magnitude bits a conversion of this width produces
  function automatic logic [14:0] mag_mask(input logic [3:0] bits);
    logic [14:0] low;
    low = (15'h1 << (MAX_BITS - bits)) - 15'h1;
    return ~low;
  endfunction

endpackage

/* sum_if.sv */
// Result and sum carrier between the sequencer and the accumulator unit
`timescale 1ns/1ps
interface sum_if;
  logic tick;
  logic [7:0] sum_ctrl;
  logic [15:0] current_res;
  logic [15:0] itemp_res;
  logic [15:0] etemp_res;
  logic [15:0] aux_res;
  logic [31:0] discharge_sum;
  logic [31:0] charge_sum;
  logic [31:0] temp_sum;
  logic [31:0] aux_voltage_sum;
  logic [31:0] discharge_time_count;
  logic [31:0] charge_time_count;
  modport src (output tick, sum_ctrl, current_res, itemp_res, etemp_res, aux_res,
    input discharge_sum, charge_sum, temp_sum, aux_voltage_sum, discharge_time_count,
    charge_time_count);
  modport acc (input tick, sum_ctrl, current_res, itemp_res, etemp_res, aux_res,
    output discharge_sum, charge_sum, temp_sum, aux_voltage_sum, discharge_time_count,
    charge_time_count);
endinterface

/* conv_timer.sv */
// Conversion duration timer: one unit times two to the width plus one
`timescale 1ns/1ps
module conv_timer #(
  parameter int UNIT_CYC = gauge_pkg::CONV_UNIT_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic start,
  input wire logic [3:0] bits,
  output logic done
);
  import gauge_pkg::*;

  logic [31:0] count;
  logic busy;
  logic [31:0] period;
  logic [31:0] elapsed;
  logic [31:0] want;

  // Shift amount widened so a 15-bit width does not wrap to zero
  assign period = 32'(UNIT_CYC) << ({1'b0, bits} + 5'h1);
  assign done = busy && (count == 32'h0);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      count <= 32'h0;
      busy <= 1'b0;
    end else if (start) begin
      count <= period - 32'h1;
      busy <= 1'b1;
    end else if (done) begin
      busy <= 1'b0;
    end else if (busy) begin
      count <= count - 32'h1;
    end
  end

  // Helper: cycles since start, checked against the expected length
  always_ff @(posedge clock) begin
    if (!rstn) begin
      elapsed <= 32'h0;
      want <= 32'h0;
    end else if (start) begin
      elapsed <= 32'h1;
      want <= period;
    end else if (busy) begin
      elapsed <= elapsed + 32'h1;
    end
  end

  chk_conv_length: assert property (@(posedge clock) disable iff (!rstn)
    done |-> elapsed == want)
    else $error("conversion length differs from unit times two to n plus one");

endmodule // conv_timer

/* sum_unit.sv */
// Four 32-bit sums and the two elapsed time counters, updated on each tick
`timescale 1ns/1ps
module sum_unit (
  input wire logic clock,
  input wire logic rstn,
  sum_if.acc sb
);
  import gauge_pkg::*;

  logic cur_sign;
  logic [31:0] cur_mag;
  logic cur_live;
  logic charge_en;
  logic [15:0] temp_src;

  // Only the current slot feeds charge, discharge and both time counters
  assign cur_sign = sb.current_res[SIGN_BIT];
  assign cur_mag = {17'h0, sb.current_res[MAG_W-1:0]};
  assign cur_live = (cur_mag != 32'h0);
  assign charge_en = sb.sum_ctrl[SUM_EN_BIT];
  assign temp_src = sb.sum_ctrl[TEMP_SRC_BIT] ? sb.etemp_res : sb.itemp_res;

  // Sums wrap modulo two to the 32nd; power-on loads the reset value
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sb.discharge_sum <= SUM_RST;
      sb.charge_sum <= SUM_RST;
      sb.temp_sum <= SUM_RST;
      sb.aux_voltage_sum <= SUM_RST;
      sb.discharge_time_count <= SUM_RST;
      sb.charge_time_count <= SUM_RST;
    end else if (sb.tick) begin
      if (charge_en && !cur_sign)
        sb.charge_sum <= sb.charge_sum + cur_mag;
      if (charge_en && cur_sign)
        sb.discharge_sum <= sb.discharge_sum + cur_mag;
      if (sb.sum_ctrl[TEMP_EN_BIT])
        sb.temp_sum <= sb.temp_sum + {16'h0, temp_src};
      if (sb.sum_ctrl[AUX_EN_BIT])
        sb.aux_voltage_sum <= sb.aux_voltage_sum + {16'h0, sb.aux_res};
      if (!cur_sign && cur_live)
        sb.charge_time_count <= sb.charge_time_count + TIME_STEP;
      if (cur_sign && cur_live)
        sb.discharge_time_count <= sb.discharge_time_count + TIME_STEP;
    end
  end

  chk_charge_add: assert property (@(posedge clock) disable iff (!rstn)
    sb.tick && charge_en && !cur_sign |=> sb.charge_sum == $past(sb.charge_sum) + $past(cur_mag)
    && sb.discharge_sum == $past(sb.discharge_sum))
    else $error("charge sum did not take the magnitude");
  chk_discharge_add: assert property (@(posedge clock) disable iff (!rstn)
    sb.tick && charge_en && cur_sign |=> sb.discharge_sum ==
    $past(sb.discharge_sum) + $past(cur_mag) && sb.charge_sum == $past(sb.charge_sum))
    else $error("discharge sum did not take the magnitude");
  chk_sum_gate: assert property (@(posedge clock) disable iff (!rstn)
    !charge_en |=> $stable(sb.charge_sum) && $stable(sb.discharge_sum))
    else $error("charge or discharge sum moved while disabled");
  chk_ctime_step: assert property (@(posedge clock) disable iff (!rstn)
    sb.tick && !cur_sign && cur_live |=> sb.charge_time_count ==
    $past(sb.charge_time_count) + TIME_STEP)
    else $error("charge time count did not step");
  chk_dtime_step: assert property (@(posedge clock) disable iff (!rstn)
    sb.tick && cur_sign && cur_live |=> sb.discharge_time_count ==
    $past(sb.discharge_time_count) + TIME_STEP)
    else $error("discharge time count did not step");
  chk_sum_idle: assert property (@(posedge clock) disable iff (!rstn)
    !sb.tick |=> $stable(sb.temp_sum) && $stable(sb.aux_voltage_sum))
    else $error("sum moved between ticks");

  cov_charge: cover property (@(posedge clock) disable iff (!rstn)
    sb.tick && charge_en && !cur_sign && cur_live);
  cov_discharge: cover property (@(posedge clock) disable iff (!rstn)
    sb.tick && charge_en && cur_sign && cur_live);

endmodule // sum_unit

/* charge_accumulator_control.sv */
// Converter sequencing, channel control registers and sum routing for the gauge
`timescale 1ns/1ps
module charge_accumulator_control #(
  parameter int TICK_CYC = gauge_pkg::TICK_CYC,
  parameter int CONV_UNIT_CYC = gauge_pkg::CONV_UNIT_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic host_wr,
  input wire logic [gauge_pkg::ADDR_W-1:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [31:0] host_rdata,
  input wire logic conv_sign,
  input wire logic [gauge_pkg::MAG_W-1:0] conv_mag,
  output logic conv_start,
  output logic conv_active,
  output logic [2:0] conv_mux,
  output logic conv_ref,
  output logic [3:0] conv_bits,
  output logic thermistor_bias_en,
  output logic update_tick
);
  import gauge_pkg::*;

  // ***************************************************************
  // Declarations
  // ***************************************************************
  logic [7:0] ctrl [NUM_CH];
  logic [15:0] result [NUM_CH];
  logic [7:0] sum_control_reg;
  seq_e state;
  seq_e next_state;
  logic [2:0] slot;
  logic [2:0] next_slot;
  logic [7:0] cur_ctrl;
  logic [2:0] cur_slot;
  logic [31:0] tick_count;
  logic conv_done;
  logic slot_enabled;
  logic launch;
  logic [2:0] raw_sel;
  logic [2:0] eff_sel;
  logic [3:0] launch_bits;
  logic [14:0] stored_mag;
  logic [15:0] stored_word;
  logic [31:0] next_rdata;
  logic wr_ctrl;
  logic wr_sum_ctrl;
  logic [2:0] wr_slot;
  logic [2:0] rd_slot;
  sum_if sb ();

  // ***************************************************************
  // Host register writes
  // ***************************************************************
  assign wr_slot = host_addr[2:0];
  assign wr_ctrl = host_wr && (host_addr < A_RES_BASE) && (wr_slot != CH_RSVD);
  assign wr_sum_ctrl = host_wr && (host_addr == A_SUM_CTRL);

  // The reserved slot has no control byte; its writes are dropped so it can never run
  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ctrl[i] <= CTRL_RST;
      end
    end else if (wr_ctrl) begin
      ctrl[wr_slot] <= host_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      sum_control_reg <= SUM_CTRL_RST;
    end else if (wr_sum_ctrl) begin
      sum_control_reg <= host_wdata;
    end
  end

  // ***************************************************************
  // Half-second update tick
  // ***************************************************************
  assign update_tick = (tick_count == 32'(TICK_CYC - 1));

  always_ff @(posedge clock) begin
    if (!rstn) begin
      tick_count <= 32'h0;
    end else if (update_tick) begin
      tick_count <= 32'h0;
    end else begin
      tick_count <= tick_count + 32'h1;
    end
  end

  // ***************************************************************
  // Slot sequencer
  // ***************************************************************
  assign slot_enabled = ctrl[slot][EN_BIT];
  assign launch = (state == S_PICK) && slot_enabled;
  assign conv_start = launch;
  assign raw_sel = ctrl[slot][SEL_MSB:SEL_LSB];
  // The zero-cal slot always grounds the input, whatever its select field holds
  assign eff_sel = (slot == CH_ZERO) ? SEL_ZERO : raw_sel;
  assign launch_bits = res_bits(ctrl[slot]);

  always_comb begin
    next_state = state;
    next_slot = slot;
    unique case (state)
      S_PICK: begin
        if (slot_enabled) begin
          next_state = S_CONV;
        end else begin
          next_slot = slot + 3'h1;
        end
      end
      S_CONV: begin
        if (conv_done) begin
          next_state = S_PICK;
          next_slot = slot + 3'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state <= S_PICK;
      slot <= CH_CURRENT;
    end else begin
      state <= next_state;
      slot <= next_slot;
    end
  end

  // Settings are frozen at launch so a host write cannot disturb a running conversion
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cur_ctrl <= CTRL_RST;
      cur_slot <= CH_CURRENT;
      conv_active <= 1'b0;
      conv_mux <= SEL_SENSE;
      conv_ref <= 1'b0;
      conv_bits <= MIN_BITS;
    end else if (launch) begin
      cur_ctrl <= ctrl[slot];
      cur_slot <= slot;
      conv_active <= 1'b1;
      conv_mux <= eff_sel;
      conv_ref <= ctrl[slot][REF_BIT];
      conv_bits <= launch_bits;
    end else if (conv_done) begin
      conv_active <= 1'b0;
    end
  end

  // Bias current is wasted power outside a thermistor conversion
  assign thermistor_bias_en = conv_active && (conv_mux == SEL_THERM);

  conv_timer #(
    .UNIT_CYC(CONV_UNIT_CYC)
  ) u_timer (
    .clock(clock),
    .rstn(rstn),
    .start(launch),
    .bits(launch_bits),
    .done(conv_done)
  );

  // ***************************************************************
  // Result capture
  // ***************************************************************
  assign stored_mag = conv_mag & mag_mask(conv_bits);
  assign stored_word = {conv_sign, stored_mag};

  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        result[i] <= RES_RST;
      end
    end else if (conv_done) begin
      result[cur_slot] <= stored_word;
    end
  end

  // ***************************************************************
  // Sum routing
  // ***************************************************************
  assign sb.tick = update_tick;
  assign sb.sum_ctrl = sum_control_reg;
  assign sb.current_res = result[CH_CURRENT];
  assign sb.itemp_res = result[CH_ITEMP];
  assign sb.etemp_res = result[CH_ETEMP];
  assign sb.aux_res = result[CH_AUX];

  sum_unit u_sums (
    .clock(clock),
    .rstn(rstn),
    .sb(sb.acc)
  );

  // ***************************************************************
  // Host register reads
  // ***************************************************************
  assign rd_slot = host_addr[2:0];

  always_comb begin
    next_rdata = 32'h0;
    if (host_addr < A_RES_BASE) begin
      next_rdata = {24'h0, ctrl[rd_slot]};
    end else if (host_addr < A_SUM_CTRL) begin
      next_rdata = {16'h0, result[rd_slot]};
    end else begin
      unique case (host_addr)
        A_SUM_CTRL: next_rdata = {24'h0, sum_control_reg};
        A_DSUM: next_rdata = sb.discharge_sum;
        A_CSUM: next_rdata = sb.charge_sum;
        A_TSUM: next_rdata = sb.temp_sum;
        A_ASUM: next_rdata = sb.aux_voltage_sum;
        A_DTIME: next_rdata = sb.discharge_time_count;
        A_CTIME: next_rdata = sb.charge_time_count;
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      host_rdata <= 32'h0;
    end else begin
      host_rdata <= next_rdata;
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  chk_sense_route: assert property (@(posedge clock) disable iff (!rstn)
    launch && raw_sel == SEL_SENSE && slot != CH_ZERO |=> conv_mux == SEL_SENSE)
    else $error("select 000 did not route the sense input");

  chk_pack_route: assert property (@(posedge clock) disable iff (!rstn)
    launch && raw_sel == SEL_PACK && slot != CH_ZERO |=> conv_mux == SEL_PACK)
    else $error("select 011 did not route the pack voltage");

  chk_res_ref: assert property (@(posedge clock) disable iff (!rstn)
    launch |=> conv_active && conv_bits == MIN_BITS + {1'b0, $past(ctrl[slot][RES_MSB:RES_LSB])}
    && conv_ref == $past(ctrl[slot][REF_BIT]))
    else $error("resolution or reference not taken from the control byte");

  chk_ten_bits: assert property (@(posedge clock) disable iff (!rstn)
    launch && ctrl[slot][RES_MSB:RES_LSB] == 3'h2 |-> launch_bits == 4'ha)
    else $error("resolution code 010 did not give ten bits");

  chk_bias_only: assert property (@(posedge clock) disable iff (!rstn)
    thermistor_bias_en |-> conv_active && conv_mux == SEL_THERM)
    else $error("thermistor bias on outside a thermistor conversion");

  chk_zero_ground: assert property (@(posedge clock) disable iff (!rstn)
    launch && slot == CH_ZERO |=> conv_mux == SEL_ZERO && conv_active)
    else $error("zero-cal slot did not ground the converter input");

  chk_zero_store: assert property (@(posedge clock) disable iff (!rstn)
    conv_done && cur_slot == CH_ZERO |=> !conv_active
    && result[CH_ZERO] == $past(stored_word))
    else $error("zero-cal result not stored");

  chk_skip_slot: assert property (@(posedge clock) disable iff (!rstn)
    state == S_PICK && !slot_enabled |=> state == S_PICK && slot == $past(slot) + 3'h1)
    else $error("disabled slot was not skipped to the next");

  chk_pad_zero: assert property (@(posedge clock) disable iff (!rstn)
    conv_done |=> (result[$past(cur_slot)][MAG_W-1:0] & ~mag_mask($past(conv_bits))) == 15'h0
    && result[$past(cur_slot)][SIGN_BIT] == $past(conv_sign))
    else $error("result padding or sign placement wrong");

  chk_tick_period: assert property (@(posedge clock) disable iff (!rstn)
    update_tick |=> !update_tick && tick_count == 32'h0)
    else $error("update tick not followed by a fresh period");

  chk_tick_gap: assert property (@(posedge clock) disable iff (!rstn)
    !update_tick |=> tick_count == $past(tick_count) + 32'h1)
    else $error("tick counter did not advance between ticks");

  chk_rsvd_idle: assert property (@(posedge clock) disable iff (!rstn)
    !(launch && slot == CH_RSVD))
    else $error("reserved slot launched a conversion");

  chk_slot_order: assert property (@(posedge clock) disable iff (!rstn)
    state == S_CONV && conv_done |=> state == S_PICK && slot == $past(slot) + 3'h1)
    else $error("next slot not examined after a conversion");

  chk_ctrl_write: assert property (@(posedge clock) disable iff (!rstn)
    wr_ctrl |=> ctrl[$past(wr_slot)] == $past(host_wdata))
    else $error("control byte write did not land");

  chk_sum_ctrl_write: assert property (@(posedge clock) disable iff (!rstn)
    wr_sum_ctrl |=> sum_control_reg == $past(host_wdata))
    else $error("sum control write did not land");

  chk_conv_frozen: assert property (@(posedge clock) disable iff (!rstn)
    conv_active |=> $stable(conv_mux) && $stable(conv_ref) && $stable(conv_bits))
    else $error("conversion settings changed mid-conversion");

  chk_bias_during: assert property (@(posedge clock) disable iff (!rstn)
    conv_active && conv_mux == SEL_THERM |-> thermistor_bias_en)
    else $error("thermistor bias off during a thermistor conversion");

  chk_res_hold: assert property (@(posedge clock) disable iff (!rstn)
    !conv_done |=> $stable(result[CH_CURRENT]))
    else $error("current result changed outside a conversion end");

  // ***************************************************************
  // Coverage
  // ***************************************************************
  cov_full_cycle: cover property (@(posedge clock) disable iff (!rstn)
    conv_done && cur_slot == CH_CURRENT);
  cov_skip: cover property (@(posedge clock) disable iff (!rstn)
    state == S_PICK && !slot_enabled);
  cov_therm: cover property (@(posedge clock) disable iff (!rstn)
    $rose(thermistor_bias_en));

endmodule // charge_accumulator_control

/* conv_model.sv */
// Behavioural converter standing at the far side of the result path
`timescale 1ns/1ps
module conv_model (
  input wire logic clock,
  input wire logic conv_active,
  input wire logic sign_in,
  input wire logic [14:0] mag_in,
  output logic conv_sign,
  output logic [14:0] conv_mag
);
  logic was_active = 1'b0;
  initial conv_sign = 1'b0;
  initial conv_mag = 15'h0000;
  always @(posedge clock) begin
    if (conv_active && !was_active) begin
      conv_sign <= sign_in;
      conv_mag <= mag_in;
    end else if (!conv_active) begin
      // Idle lines toggle so a result taken outside a conversion never looks valid
      conv_sign <= ~conv_sign;
      conv_mag <= ~conv_mag;
    end
    was_active <= conv_active;
  end
endmodule // conv_model

/* tb.sv */
// Self-checking bench for the charge accumulator control block
`timescale 1ns/1ps
module tb;
  import gauge_pkg::*;
  typedef struct {logic wr; logic [4:0] addr; logic [7:0] wdata; logic [31:0] exp;} row_s;
  localparam int TICK = 200;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic host_wr = 1'b0;
  logic [4:0] host_addr = 5'h00;
  logic [7:0] host_wdata = 8'h00;
  logic [31:0] host_rdata;
  logic conv_sign, conv_start, conv_active, conv_ref, thermistor_bias_en, update_tick;
  logic [14:0] conv_mag;
  logic [2:0] conv_mux;
  logic [3:0] conv_bits;
  logic sign_in = 1'b0;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  logic [31:0] rv;
  logic [31:0] sv [2][4];
  // Control bytes written here keep bit 7 clear, except 8'hff to the reserved slot, which is dropped, so no stray conversion starts
  row_s rows [9] = '{'{1'b0, 5'h00, 8'h00, 32'h0}, '{1'b0, 5'h08, 8'h00, 32'h0},
    '{1'b0, 5'h12, 8'h00, 32'h0}, '{1'b0, 5'h10, 8'h00, 32'h0},
    '{1'b1, 5'h03, 8'h2b, 32'h2b}, '{1'b1, 5'h01, 8'h29, 32'h29},
    '{1'b1, 5'h04, 8'hff, 32'h0}, '{1'b1, 5'h11, 8'hff, 32'h0}, '{1'b0, 5'h1f, 8'h00, 32'h0}};

  charge_accumulator_control #(.TICK_CYC(TICK), .CONV_UNIT_CYC(1)) dut (.clock(clock),
    .rstn(rstn), .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .conv_sign(conv_sign), .conv_mag(conv_mag),
    .conv_start(conv_start), .conv_active(conv_active), .conv_mux(conv_mux),
    .conv_ref(conv_ref), .conv_bits(conv_bits), .thermistor_bias_en(thermistor_bias_en),
    .update_tick(update_tick));
  conv_model partner (.clock(clock), .conv_active(conv_active), .sign_in(sign_in),
    .mag_in(15'h7fff), .conv_sign(conv_sign), .conv_mag(conv_mag));

  initial begin
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    step();
    host_wr = 1'b1;
    host_addr = a;
    host_wdata = d;
    step();
    host_wr = 1'b0;
  endtask
  // Address held over two edges so the registered read data has surely landed
  task automatic rd(input logic [4:0] a);
    step();
    host_addr = a;
    step();
    step();
    rv = host_rdata;
  endtask
  task automatic wait_start();
    step();
    while (conv_start !== 1'b1) step();
  endtask
  task automatic wait_end();
    step();
    while (conv_active === 1'b1) step();
  endtask
  task automatic wait_tick();
    step();
    while (update_tick !== 1'b1) step();
  endtask
  task automatic span(input int exp);
    n = 0;
    while (conv_active === 1'b1) begin
      n++;
      step();
    end
    cmp(32'(n), 32'(exp));
  endtask
  // Two snapshots one tick apart; only differences are judged, so history cancels
  task automatic pair(input logic [31:0] c, input logic [31:0] d,
      input logic [31:0] ct, input logic [31:0] dt);
    for (int k = 0; k < 2; k++) begin
      wait_tick();
      rd(A_CSUM);
      sv[k][0] = rv;
      rd(A_DSUM);
      sv[k][1] = rv;
      rd(A_CTIME);
      sv[k][2] = rv;
      rd(A_DTIME);
      sv[k][3] = rv;
    end
    cmp(sv[1][0] - sv[0][0], c);
    cmp(sv[1][1] - sv[0][1], d);
    cmp(sv[1][2] - sv[0][2], ct);
    cmp(sv[1][3] - sv[0][3], dt);
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  initial begin
    repeat (2) @(posedge clock);
    #1;
    rstn = 1'b1;
    cmp({conv_active, conv_bits, thermistor_bias_en}, {1'b0, 4'h8, 1'b0});
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr);
      cmp(rv, rows[i].exp);
    end
    $display("register table test done");
    wr(5'h00, 8'h80);
    wait_start();
    step();
    cmp({conv_mux, conv_ref, conv_bits}, {3'h0, 1'b0, 4'h8});
    span(512);
    rd(A_RES_BASE);
    cmp(rv, 32'h7f80);
    wait_tick();
    step();
    n = 1;
    while (update_tick !== 1'b1) begin
      n++;
      step();
    end
    cmp(32'(n), 32'(TICK));
    $display("current conversion test done");
    wr(A_SUM_CTRL, 8'h01);
    pair(32'h7f80, 32'h0, 32'h1, 32'h0);
    sign_in = 1'b1;
    repeat (2) begin
      wait_start();
      wait_end();
    end
    pair(32'h0, 32'h7f80, 32'h0, 32'h1);
    wr(A_SUM_CTRL, 8'h00);
    pair(32'h0, 32'h0, 32'h0, 32'h1);
    $display("sum steering test done");
    // Reprogram inside a current conversion so the next launches come in a fixed order
    wait_start();
    step();
    wr(5'h00, 8'h00);
    wr(5'h02, 8'h8a);
    wr(5'h06, 8'ha0);
    wait_start();
    step();
    cmp({conv_mux, conv_ref, thermistor_bias_en}, {3'h2, 1'b1, 1'b1});
    wait_end();
    cmp({31'h0, thermistor_bias_en}, 32'h0);
    wait_start();
    step();
    cmp({conv_mux, conv_bits, thermistor_bias_en}, {3'h6, 4'ha, 1'b0});
    span(2048);
    rd(5'h0e);
    cmp(rv, 32'hffe0);
    $display("thermistor and zero slot test done");
    wr(A_SUM_CTRL, 8'h0a);
    for (int k = 0; k < 2; k++) begin
      wait_tick();
      rd(A_TSUM);
      sv[k][0] = rv;
    end
    cmp(sv[1][0] - sv[0][0], 32'hff80);
    $display("temperature sum test done");
    tally_and_finish();
  end
endmodule // tb
